// ---- src/bbcsc_defs.vh ----
// bbcsc_defs.vh: constants of the backoff, address float and cache control
// assumes inclusion by bare name from the design file
`ifndef BBCSC_DEFS_VH
`define BBCSC_DEFS_VH
// cache geometry
`define BBCSC_ADDR_W 32
`define BBCSC_LINES 16
`define BBCSC_IDX_W 4
`define BBCSC_OFS_LSB 4
`define BBCSC_TAG_W 24
`define BBCSC_BEATS 4
// core request kinds
`define BBCSC_KIND_READ 2'h0
`define BBCSC_KIND_WRITE 2'h1
`define BBCSC_KIND_FETCH 2'h2
// cycle state codes
`define BBCSC_ST_IDLE 3'h0
`define BBCSC_ST_ADDR 3'h1
`define BBCSC_ST_DATA 3'h2
`define BBCSC_ST_BACKOFF 3'h3
`define BBCSC_ST_HOLD 3'h4
// reset values
`define BBCSC_CNT_RST 2'h0
`endif

// ---- src/bbcsc_ctrl.v ----
// bbcsc_ctrl.v: bus cycle engine with backoff, address float, snoop
// invalidation, line fill control, flush and page attribute pins.
// assumes core_clk is the bus clock; the core holds its request stable
// until cyc_done; page attributes come from the active translation level.
`include "bbcsc_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - backoff sampled low floats all hold-floated pins next clock.
// - hold acknowledge never asserted because of backoff.
// - backoff together with a ready wins; the ready is ignored.
// - bus stays floated while backoff is held low.
// - a cycle cut by backoff restarts from its first beat.
// - address float request floats the address bus next clock.
// - address float releases address only; other outputs keep driving.
// - external strobe marks a valid address used for invalidation.
// - cacheable low before first ready turns the cycle into a fill.
// - line written only if cacheable low before last ready again.
// - single clock flush assertion clears the whole cache.
// - with paging on, attribute pins follow the active entry bits.
// - with paging off both attributes read as zero everywhere.
// - attribute pins timed like the cycle definition pins.
// - attribute pins undriven during bus hold.
// - cache-off pin masked by the cache disable bit.
// - bus hold floats most pins; backoff floats the same set.
module bbcsc_ctrl (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // core request side
  input wire cyc_req,
  input wire [1:0] cyc_kind,
  input wire [`BBCSC_ADDR_W-1:0] cyc_addr,
  input wire [31:0] cyc_wdata,
  output wire cyc_done,
  output reg [31:0] cyc_rdata,
  output reg cyc_hit,
  // paging controls
  input wire paging_on,
  input wire attr_write_through,
  input wire attr_cache_off,
  input wire cache_disable_bit,
  // arbitration pins (all synchronous pins)
  input wire bus_hold_req,
  output reg bus_yield_ack,
  input wire bus_backoff_n,
  input wire address_float_request,
  // handshake pins
  input wire ready_n,
  input wire burst_ready_n,
  input wire cacheable_n,
  input wire external_addr_strobe_n,
  input wire flush_n,
  // address bus, three signals per pin group
  input wire [`BBCSC_ADDR_W-1:0] addr_in,
  output reg [`BBCSC_ADDR_W-1:0] addr_out,
  output wire addr_oe,
  // data bus
  output reg [31:0] data_out,
  output wire data_oe,
  input wire [31:0] data_in,
  // cycle control and definition
  output reg addr_strobe_n,
  output reg mem_io,
  output reg data_code,
  output reg write_read,
  output wire ctl_oe,
  output reg page_write_through,
  output reg page_cache_off,
  output wire attr_oe
);

////////////////////////////////////////////////////////////////////////////
// helpers
function [`BBCSC_IDX_W-1:0] line_idx;
  input [`BBCSC_ADDR_W-1:0] a;
  begin
    line_idx = a[`BBCSC_OFS_LSB+`BBCSC_IDX_W-1:`BBCSC_OFS_LSB];
  end
endfunction

function [`BBCSC_TAG_W-1:0] line_tag;
  input [`BBCSC_ADDR_W-1:0] a;
  begin
    line_tag = a[`BBCSC_ADDR_W-1:`BBCSC_ADDR_W-`BBCSC_TAG_W];
  end
endfunction

// next word of a burst, wrapping inside the line
function [1:0] next_word;
  input [`BBCSC_ADDR_W-1:0] a;
  begin
    next_word = a[3:2] + 2'h1;
  end
endfunction

// stored tag against the tag part of an address
function tag_match;
  input [`BBCSC_TAG_W-1:0] stored;
  input [`BBCSC_ADDR_W-1:0] a;
  begin
    tag_match = (stored == line_tag(a));
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// state
reg [2:0] state;
reg [2:0] next_state;
reg [1:0] beat;
reg fill;
reg fill_ok;
reg cacheable_seen;
reg aflt;
reg [2:0] flush_sync;
reg [`BBCSC_LINES-1:0] valid;
reg [`BBCSC_TAG_W-1:0] tag_mem [0:`BBCSC_LINES-1];
reg [31:0] data_mem [0:`BBCSC_LINES*`BBCSC_BEATS-1];
wire backoff = ~bus_backoff_n;
wire any_ready = ~ready_n | ~burst_ready_n;
wire floated = (state == `BBCSC_ST_BACKOFF) | (state == `BBCSC_ST_HOLD);
// a one clock flush never shows in stages two and three together,
// so the request counts on stage two low while stage three is still high
wire flush_now = ~flush_sync[1] & flush_sync[2];
wire [`BBCSC_IDX_W-1:0] req_idx = line_idx(cyc_addr);
wire [`BBCSC_IDX_W-1:0] snp_idx = line_idx(addr_in);
wire pcd_eff = paging_on & (attr_cache_off | cache_disable_bit);
wire pwt_eff = paging_on & attr_write_through;
wire can_cache = (cyc_kind != `BBCSC_KIND_WRITE) & ~pcd_eff &
                 ~cache_disable_bit;
wire cache_hit = valid[req_idx] & tag_match(tag_mem[req_idx], cyc_addr);
// first ready of a cacheable cycle with cacheable seen turns it into a
// fill; without this term the first beat would end the cycle early
wire fill_start = (beat == 2'h0) & ~fill & can_cache & cacheable_seen;
wire last_beat = ~(fill | fill_start) | (beat == 2'h3);
// a ready is honoured only without backoff in the same clock
wire ready_taken = (state == `BBCSC_ST_DATA) & any_ready & ~backoff;

////////////////////////////////////////////////////////////////////////////
// output enables: hold and backoff release the same pin set
assign addr_oe = ~floated & ~aflt;
assign data_oe = ~floated & (state == `BBCSC_ST_DATA) & write_read;
assign ctl_oe = ~floated;
assign attr_oe = ~floated;
assign cyc_done = ready_taken & last_beat;

////////////////////////////////////////////////////////////////////////////
// flush synchroniser, assertion counts when stage two is low while stage three is still high
always @(posedge core_clk or negedge arst_n) begin
  if (!arst_n) begin
    flush_sync <= 3'h7;
  end else begin
    flush_sync <= {flush_sync[1:0], flush_n};
  end
end

////////////////////////////////////////////////////////////////////////////
// address float follows the request one clock later
always @(posedge core_clk or negedge arst_n) begin
  if (!arst_n) begin
    aflt <= 1'b0;
  end else begin
    aflt <= address_float_request;
  end
end

////////////////////////////////////////////////////////////////////////////
// next cycle state
always @* begin
  next_state = state;
  case (state)
    `BBCSC_ST_IDLE: begin
      if (backoff) begin
        next_state = `BBCSC_ST_BACKOFF;
      end else if (bus_hold_req) begin
        next_state = `BBCSC_ST_HOLD;
      end else if (cyc_req & ~cyc_done & ~(can_cache & cache_hit)) begin
        next_state = `BBCSC_ST_ADDR;
      end
    end
    `BBCSC_ST_ADDR: begin
      if (backoff) begin
        next_state = `BBCSC_ST_BACKOFF;
      end else begin
        next_state = `BBCSC_ST_DATA;
      end
    end
    `BBCSC_ST_DATA: begin
      if (backoff) begin
        next_state = `BBCSC_ST_BACKOFF;
      end else if (ready_taken & last_beat) begin
        next_state = `BBCSC_ST_IDLE;
      end
    end
    `BBCSC_ST_BACKOFF: begin
      if (!backoff) begin
        next_state = `BBCSC_ST_IDLE;
      end
    end
    `BBCSC_ST_HOLD: begin
      if (backoff) begin
        next_state = `BBCSC_ST_BACKOFF;
      end else if (!bus_hold_req) begin
        next_state = `BBCSC_ST_IDLE;
      end
    end
    default: begin
      next_state = `BBCSC_ST_IDLE;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////
// cycle engine: state, beat count and fill tracking
always @(posedge core_clk or negedge arst_n) begin
  if (!arst_n) begin
    state <= `BBCSC_ST_IDLE;
    beat <= `BBCSC_CNT_RST;
    fill <= 1'b0;
    fill_ok <= 1'b0;
  end else begin
    state <= next_state;
    if (next_state == `BBCSC_ST_ADDR) begin
      // a restarted cycle begins again from beat zero
      beat <= `BBCSC_CNT_RST;
      fill <= 1'b0;
      fill_ok <= 1'b0;
    end else if (ready_taken && fill_start) begin
      // cacheable seen before the first ready: the cycle becomes a fill
      fill <= 1'b1;
      fill_ok <= 1'b1;
      beat <= beat + 2'h1;
    end else if (ready_taken && fill) begin
      beat <= beat + 2'h1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// address phase: strobe, address, definition and attribute pins
always @(posedge core_clk or negedge arst_n) begin
  if (!arst_n) begin
    addr_strobe_n <= 1'b1;
    addr_out <= {`BBCSC_ADDR_W{1'b0}};
    data_out <= 32'h0000_0000;
    mem_io <= 1'b0;
    data_code <= 1'b0;
    write_read <= 1'b0;
    page_write_through <= 1'b0;
    page_cache_off <= 1'b0;
  end else begin
    // strobe is a single clock pulse in the address phase
    addr_strobe_n <= 1'b1;
    if (next_state == `BBCSC_ST_ADDR) begin
      addr_strobe_n <= 1'b0;
      addr_out <= cyc_addr;
      data_out <= cyc_wdata;
      mem_io <= 1'b1;
      data_code <= (cyc_kind != `BBCSC_KIND_FETCH);
      write_read <= (cyc_kind == `BBCSC_KIND_WRITE);
      // attributes share the definition pins' edge
      page_write_through <= pwt_eff;
      page_cache_off <= pcd_eff;
    end else if (ready_taken && (fill || fill_start)) begin
      // burst address walks the words of the line, wrapping
      addr_out[3:2] <= next_word(addr_out);
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// hold acknowledge and cacheable sampling
always @(posedge core_clk or negedge arst_n) begin
  if (!arst_n) begin
    bus_yield_ack <= 1'b0;
    cacheable_seen <= 1'b0;
  end else begin
    // acknowledge only on the ordinary hold path
    bus_yield_ack <= (next_state == `BBCSC_ST_HOLD);
    // cacheable sampled each clock, used the clock a ready arrives
    cacheable_seen <= ~cacheable_n;
  end
end

////////////////////////////////////////////////////////////////////////////
// read data return: cache hit, single transfer or the wanted fill word
always @(posedge core_clk or negedge arst_n) begin
  if (!arst_n) begin
    cyc_rdata <= 32'h0000_0000;
    cyc_hit <= 1'b0;
  end else begin
    cyc_hit <= 1'b0;
    if (state == `BBCSC_ST_IDLE && cyc_req && can_cache && cache_hit &&
        !backoff) begin
      cyc_rdata <= data_mem[{req_idx, cyc_addr[3:2]}];
      cyc_hit <= 1'b1;
    end
    if (ready_taken) begin
      // a fill hands back only the word the core asked for
      if (!(fill || fill_start) || addr_out[3:2] == cyc_addr[3:2]) begin
        cyc_rdata <= data_in;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// line data store, written beat by beat during a fill
always @(posedge core_clk) begin
  if (ready_taken && (fill || fill_start)) begin
    data_mem[{line_idx(addr_out), addr_out[3:2]}] <= data_in;
  end
end

////////////////////////////////////////////////////////////////////////////
// tag and valid store: flush, snoop invalidation, fill commit
always @(posedge core_clk or negedge arst_n) begin
  if (!arst_n) begin
    valid <= {`BBCSC_LINES{1'b0}};
  end else if (flush_now) begin
    valid <= {`BBCSC_LINES{1'b0}};
  end else begin
    if (ready_taken && fill && beat == 2'h3 && fill_ok && cacheable_seen) begin
      valid[line_idx(addr_out)] <= 1'b1;
      tag_mem[line_idx(addr_out)] <= line_tag(addr_out);
    end
    // snoop address only valid while strobe low; miss is harmless
    if (!external_addr_strobe_n && valid[snp_idx] &&
        tag_match(tag_mem[snp_idx], addr_in)) begin
      valid[snp_idx] <= 1'b0;
    end
  end
end

endmodule // bbcsc_ctrl

// ---- tb/bbcsc_checker.sv ----
// checker: float, ready and page attribute pin timing
// assumes one clock domain and an async active low reset
module bbcsc_checker (
  // clock and reset
  input wire logic core_clk, arst_n,
  // arbitration and handshake
  input wire logic bus_hold_req, bus_yield_ack, bus_backoff_n,
  input wire logic address_float_request, ready_n, cyc_done,
  // paging and pins
  input wire logic paging_on, cache_disable_bit, addr_strobe_n,
  input wire logic addr_oe, data_oe, ctl_oe, attr_oe,
  input wire logic page_write_through, page_cache_off
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // all hold floated pins released
  sequence s_float; !addr_oe && !data_oe && !ctl_oe && !attr_oe; endsequence
  // address float alone, bus otherwise owned
  sequence s_afl;
    address_float_request && bus_backoff_n && !bus_hold_req && ctl_oe;
  endsequence
  property p_bus_backoff_n; !bus_backoff_n |=> s_float; endproperty
  a_bus_backoff_n: assert property (p_bus_backoff_n)
    else $error("backoff left pins driven");
  property p_noack;
    !bus_backoff_n && !bus_hold_req && !bus_yield_ack |=> !bus_yield_ack;
  endproperty
  a_noack: assert property (p_noack)
    else $error("acknowledge raised for backoff");
  property p_rdy; !bus_backoff_n && !ready_n |-> !cyc_done; endproperty
  a_rdy: assert property (p_rdy)
    else $error("ready taken beside backoff");
  property p_resume;
    $rose(ctl_oe) |-> $past(bus_backoff_n) && !$past(bus_hold_req);
  endproperty
  a_resume: assert property (p_resume)
    else $error("bus driven again under backoff");
  property p_afl; address_float_request |=> !addr_oe; endproperty
  a_afl: assert property (p_afl)
    else $error("address bus not floated");
  property p_aonly; s_afl |=> ctl_oe && attr_oe; endproperty
  a_aonly: assert property (p_aonly)
    else $error("address float released control pins");
  property p_pgoff;
    !paging_on && !addr_strobe_n |-> !page_write_through && !page_cache_off;
  endproperty
  a_pgoff: assert property (p_pgoff)
    else $error("attributes set with paging off");
  property p_cd;
    paging_on && cache_disable_bit && !addr_strobe_n |-> page_cache_off;
  endproperty
  a_cd: assert property (p_cd)
    else $error("cache off pin not masked");
  property p_hold; bus_hold_req |=> bus_yield_ack && !attr_oe; endproperty
  a_hold: assert property (p_hold)
    else $error("attributes driven in hold");
endmodule // bbcsc_checker
////////////////////////////////////////
bind bbcsc_ctrl bbcsc_checker u_chk (.core_clk, .arst_n, .bus_hold_req,
  .bus_yield_ack, .bus_backoff_n, .address_float_request, .ready_n,
  .cyc_done, .paging_on, .cache_disable_bit, .addr_strobe_n, .addr_oe,
  .data_oe, .ctl_oe, .attr_oe, .page_write_through, .page_cache_off);

// ---- tb/bbcsc_far_side.sv ----
// chipset model: answers each strobe, word data equals its address
// assumes lag and ken_mode change only between cycles
module bbcsc_far_side (
  // clock, reset and block pins
  input wire logic core_clk, arst_n, addr_strobe_n, write_read,
  input wire logic bus_backoff_n,
  input wire logic [31:0] addr_out,
  // bench controls: wait states, cacheable mode
  input wire logic [3:0] lag,
  input wire logic [1:0] ken_mode,
  // answers
  output logic ready_n, burst_ready_n, cacheable_n,
  output logic [31:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy, fill;
  logic [3:0] wait_cnt;
  logic [1:0] beat;
  logic [31:0] addr_q;
  // one cycle at a time, abandoned on backoff
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {busy, fill, ready_n, burst_ready_n, cacheable_n} <= 5'h07;
      {wait_cnt, beat, addr_q, data_in} <= 70'h0;
    end else begin
      {ready_n, burst_ready_n, cacheable_n} <= 3'h7;
      data_in <= ~data_in; // released data keeps changing
      if (!bus_backoff_n) begin
        busy <= 1'b0;
      end else if (!addr_strobe_n) begin
        busy <= 1'b1;
        fill <= ken_mode != 2'h0 && !write_read;
        cacheable_n <= !(ken_mode != 2'h0 && !write_read);
        wait_cnt <= lag;
        beat <= 2'h0;
        addr_q <= addr_out;
      end else if (busy && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
        cacheable_n <= !fill;
      end else if (busy) begin
        ready_n <= fill;
        burst_ready_n <= !fill;
        data_in <= {addr_q[31:4], addr_q[3:2] + beat, 2'h0};
        beat <= beat + 2'h1;
        busy <= fill && beat != 2'h3;
        cacheable_n <= !(fill && !(ken_mode[1] && beat == 2'h2));
      end
    end
  end
endmodule // bbcsc_far_side

// ---- tb/bbcsc_ctrl_tb_top.sv ----
// bench: core requests, snoops, flush, backoff, hold and paging modes
// assumes the far side model answers every address strobe
`include "bbcsc_defs.vh"
module bbcsc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, arst_n, cyc_req, cyc_done, cyc_hit, paging_on, got_wt;
  logic attr_write_through, attr_cache_off, cache_disable_bit, got_co;
  logic bus_hold_req, bus_yield_ack, bus_backoff_n, address_float_request;
  logic ready_n, burst_ready_n, cacheable_n, external_addr_strobe_n;
  logic flush_n, addr_oe, data_oe, addr_strobe_n, write_read, ctl_oe;
  logic attr_oe, page_write_through, page_cache_off;
  logic [1:0] cyc_kind, ken_mode;
  logic [3:0] lag;
  logic [31:0] cyc_addr, cyc_wdata, cyc_rdata, addr_in, addr_out, data_in;
  int bad_count, checks_done;
  bbcsc_ctrl dut (.core_clk, .arst_n, .cyc_req, .cyc_kind, .cyc_addr,
    .cyc_wdata, .cyc_done, .cyc_rdata, .cyc_hit, .paging_on,
    .attr_write_through, .attr_cache_off, .cache_disable_bit,
    .bus_hold_req, .bus_yield_ack, .bus_backoff_n, .address_float_request,
    .ready_n, .burst_ready_n, .cacheable_n, .external_addr_strobe_n,
    .flush_n, .addr_in, .addr_out, .addr_oe, .data_out(), .data_oe,
    .data_in, .addr_strobe_n, .mem_io(), .data_code(), .write_read,
    .ctl_oe, .page_write_through, .page_cache_off, .attr_oe);
  bbcsc_far_side far (.core_clk, .arst_n, .addr_strobe_n, .write_read,
    .bus_backoff_n, .addr_out, .lag, .ken_mode, .ready_n, .burst_ready_n,
    .cacheable_n, .data_in);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // attribute pins captured in the strobe cycle
  always @(negedge core_clk) begin
    if (!addr_strobe_n) {got_wt, got_co} <= {page_write_through, page_cache_off};
  end
  task automatic check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one core request; hit tells whether the cache should answer
  task automatic cyc(input logic [1:0] k, input logic [31:0] a, input logic hit);
    int n;
    logic h;
    cyc_req <= 1'b1;
    cyc_kind <= k;
    cyc_addr <= a;
    cyc_wdata <= ~a;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (cyc_done !== 1'b1 && cyc_hit !== 1'b1 && n < 80);
    h = cyc_hit;
    @(posedge core_clk);
    cyc_req <= 1'b0;
    #1;
    check(n < 80, 1'b1);
    check(h, hit);
    if (k != `BBCSC_KIND_WRITE) check(cyc_rdata, a);
    @(posedge core_clk);
  endtask
  // address float with one snoop address
  task automatic snoop(input logic [31:0] a);
    address_float_request <= 1'b1;
    @(posedge core_clk);
    external_addr_strobe_n <= 1'b0;
    addr_in <= a;
    #1;
    check({addr_oe, ctl_oe}, 2'b01);
    @(posedge core_clk);
    {external_addr_strobe_n, address_float_request} <= 2'b10;
    addr_in <= ~a;
    repeat (2) @(posedge core_clk);
  endtask
  initial begin
    {cyc_req, paging_on, attr_cache_off, cache_disable_bit} = 4'h0;
    {bus_hold_req, address_float_request, cyc_kind, ken_mode} = 6'h0;
    {bus_backoff_n, external_addr_strobe_n, flush_n} = 3'h7;
    {attr_write_through, arst_n, lag} = 6'h21;
    {cyc_addr, cyc_wdata, addr_in} = 96'h0;
    {bad_count, checks_done} = 0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1 check({addr_oe, data_oe, bus_yield_ack}, 3'b100);
    cyc(`BBCSC_KIND_READ, 32'h104, 1'b0);
    cyc(`BBCSC_KIND_READ, 32'h104, 1'b0);
    ken_mode <= 2'h1;
    cyc(`BBCSC_KIND_READ, 32'h200, 1'b0);
    cyc(`BBCSC_KIND_READ, 32'h204, 1'b1);
    cyc(`BBCSC_KIND_FETCH, 32'h20c, 1'b1);
    cyc(`BBCSC_KIND_WRITE, 32'h300, 1'b0);
    ken_mode <= 2'h2;
    cyc(`BBCSC_KIND_READ, 32'h410, 1'b0);
    cyc(`BBCSC_KIND_READ, 32'h410, 1'b0);
    ken_mode <= 2'h1;
    snoop(32'h900);
    cyc(`BBCSC_KIND_READ, 32'h208, 1'b1);
    snoop(32'h200);
    cyc(`BBCSC_KIND_READ, 32'h208, 1'b0);
    flush_n <= 1'b0;
    @(posedge core_clk);
    flush_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    cyc(`BBCSC_KIND_READ, 32'h200, 1'b0);
    ken_mode <= 2'h0;
    lag <= 4'h2;
    fork
      cyc(`BBCSC_KIND_READ, 32'h504, 1'b0);
      begin
        @(negedge addr_strobe_n);
        repeat (4) @(posedge core_clk);
        bus_backoff_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 check({addr_oe, data_oe, ctl_oe, attr_oe, bus_yield_ack}, 0);
        @(posedge core_clk);
        bus_backoff_n <= 1'b1;
      end
    join
    bus_hold_req <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 check({bus_yield_ack, attr_oe, addr_oe}, 3'b100);
    @(posedge core_clk);
    bus_hold_req <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      {attr_cache_off, attr_write_through} <= {i[2], ~i[2]};
      {paging_on, cache_disable_bit} <= i[1:0];
      @(posedge core_clk);
      cyc(`BBCSC_KIND_WRITE, 32'h600, 1'b0);
      check({got_wt, got_co}, {i[1] & ~i[2], i[1] & (i[0] | i[2])});
    end
    conclude();
  end
  // hang guard
  initial begin
    #200us;
    bad_count++;
    conclude();
  end
endmodule // bbcsc_ctrl_tb_top
